// [hdl/dco_ctl_pkg.sv]
// Purpose: constants shared by the primary loop holdover and oscillator control block
// Assumes: 125 MHz reference clock, AXI4-Lite register access with 32-bit data
// Notes: register offsets are byte addresses
// Contract
// - bandwidth codes 00000-10101 valid, above reserved
// - second prelock mode tracks reference, transient only
// - lost-phase mode tracks reference, transient only
// - oscillator is accumulator steered by control word
// - mode register selects oscillator write-frequency control
// - offset word is 40-bit signed two's complement
// - one word step is fixed fractional frequency
// - phase shift equals frequency change times duration
// - holdover uses stored frequency, no phase lock
// - four fields jointly choose holdover acquisition
// - manual bit selects written word as holdover
// - filter field selects averaging bandwidth
// - history field picks now, 1, 8, 64 seconds
// - mode code 01010 selects oscillator write mode
// - readback bit selects written or acquired value
package dco_ctl_pkg;
  localparam int unsigned WORD_W = 40;
  localparam int unsigned HI_W = 8;
  localparam int unsigned ACC_W = 48;
  localparam int unsigned FRAC_W = 16;
  localparam int unsigned HIST_AW = 7;

  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_BW = 8'h04;
  localparam logic [7:0] OFF_HOLD = 8'h08;
  localparam logic [7:0] OFF_WORD_LO = 8'h0c;
  localparam logic [7:0] OFF_WORD_HI = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_PHASE = 8'h18;

  localparam logic [4:0] MODE_AUTO = 5'h00;
  localparam logic [4:0] MODE_FREERUN = 5'h01;
  localparam logic [4:0] MODE_HOLDOVER = 5'h02;
  localparam logic [4:0] MODE_LOCKED = 5'h04;
  localparam logic [4:0] MODE_PRELOCK2 = 5'h05;
  localparam logic [4:0] MODE_PRELOCK = 5'h06;
  localparam logic [4:0] MODE_LOSTPHASE = 5'h07;
  localparam logic [4:0] MODE_DCO = 5'h0a;
  localparam logic [4:0] MODE_RESET = MODE_FREERUN;

  localparam logic [4:0] BW_MAX = 5'h15;
  localparam logic [4:0] BW_RESET = 5'h09;

  // hold method field positions
  localparam int unsigned HB_MAN = 0;
  localparam int unsigned HB_AVG = 1;
  localparam int unsigned HB_HIST = 2;
  localparam int unsigned HB_FILT = 4;
  localparam int unsigned HB_RDSEL = 6;
  localparam logic [6:0] HOLD_RESET = 7'h12;

  localparam logic [HIST_AW-1:0] HIST_BACK_1 = 7'h01;
  localparam logic [HIST_AW-1:0] HIST_BACK_8 = 7'h08;
  localparam logic [HIST_AW-1:0] HIST_BACK_64 = 7'h40;

  // iir shift per filter code, smaller shift means wider bandwidth
  localparam logic [4:0] FILT_SHIFT_0 = 5'h0e;
  localparam logic [4:0] FILT_SHIFT_1 = 5'h0b;
  localparam logic [4:0] FILT_SHIFT_2 = 5'h08;
  localparam logic [4:0] FILT_SHIFT_3 = 5'h05;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam longint unsigned CLK_PERIOD_NS = 8;
  localparam longint unsigned SEC_NS = 1_000_000_000;
  localparam longint unsigned SEC_CYCLES_DEF = SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned AVG_DIV_DEF = 1024;
  localparam logic [ACC_W-1:0] NOMINAL_INC_DEF = 48'h1000_0000_0000;
endpackage

// [hdl/hold_hist_mem.sv]
// Purpose: history store of averaged holdover frequency, one entry per second
// Assumes: single clock, one write and one read port
// Notes: read data come from a register, one cycle after the address
`timescale 1ns/1ps
module hold_hist_mem #(
  parameter int unsigned W = 40,
  parameter int unsigned AW = 7
) (
  input wire logic ref_clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    rdata_o <= mem[raddr_i];
  end
endmodule

// [hdl/dpll_holdover_dco_control.sv]
// Purpose: primary loop mode, bandwidth, oscillator and holdover acquisition control
// Assumes: loop_freq_i is the loop's integral frequency word on the same clock
// Notes: unmapped addresses answer SLVERR, reads of them return zero
`timescale 1ns/1ps
module dpll_holdover_dco_control #(
  parameter longint unsigned SEC_CYCLES = dco_ctl_pkg::SEC_CYCLES_DEF,
  parameter int unsigned AVG_DIV = dco_ctl_pkg::AVG_DIV_DEF,
  parameter logic [dco_ctl_pkg::ACC_W-1:0] NOMINAL_INC = dco_ctl_pkg::NOMINAL_INC_DEF
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic signed [dco_ctl_pkg::WORD_W-1:0] loop_freq_i,
  output logic [4:0] primary_loop_mode_o,
  output logic [4:0] locked_loop_bw_sel_o,
  output logic track_ref_o,
  output logic signed [dco_ctl_pkg::WORD_W-1:0] dco_freq_o,
  output logic [dco_ctl_pkg::ACC_W-1:0] dco_phase_o
);
  import dco_ctl_pkg::*;

  localparam int unsigned AVG_W = WORD_W + FRAC_W;

  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic [4:0] mode_q;
  logic [4:0] bw_q;
  logic [6:0] hold_cfg_q;
  logic [31:0] lo_stage_q;
  logic [WORD_W-1:0] word_q;
  logic [WORD_W-1:0] hold_val_q;
  logic signed [AVG_W-1:0] avg_q;
  logic signed [AVG_W:0] avg_diff;
  logic [4:0] filt_shift;
  logic [31:0] avg_div_q;
  logic [63:0] sec_cnt_q;
  logic [HIST_AW-1:0] wptr_q;
  logic [HIST_AW-1:0] back;
  logic [HIST_AW:0] fill_q;
  logic [WORD_W-1:0] hist_rdata;
  logic [WORD_W-1:0] acq;
  logic tracking;
  logic sec_tick;
  logic avg_tick;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mode_legal(input logic [4:0] m);
    return (m <= MODE_LOSTPHASE && m != 5'h03) || m == MODE_DCO;
  endfunction

  // write channel: address and data accepted in either order, answered once both are in
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q inside {OFF_MODE, OFF_BW, OFF_HOLD, OFF_WORD_LO, OFF_WORD_HI})
                       ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // illegal mode codes are dropped so the loop never sits in an undefined mode
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_q <= MODE_RESET;
    end else if (do_write && awaddr_q == OFF_MODE && wstrb_q[0] && mode_legal(wdata_q[4:0])) begin
      mode_q <= wdata_q[4:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bw_q <= BW_RESET;
    end else if (do_write && awaddr_q == OFF_BW && wstrb_q[0] && wdata_q[4:0] <= BW_MAX) begin
      bw_q <= wdata_q[4:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hold_cfg_q <= HOLD_RESET;
    end else if (do_write && awaddr_q == OFF_HOLD && wstrb_q[0]) begin
      hold_cfg_q <= wdata_q[6:0];
    end
  end

  // low 32 bits are staged; the whole word commits with the high byte
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      lo_stage_q <= 32'h0000_0000;
      word_q <= '0;
    end else if (do_write && awaddr_q == OFF_WORD_LO) begin
      lo_stage_q <= merge(lo_stage_q, wdata_q, wstrb_q);
    end else if (do_write && awaddr_q == OFF_WORD_HI) begin
      word_q <= {(wstrb_q[0] ? wdata_q[HI_W-1:0] : word_q[WORD_W-1 -: HI_W]), lo_stage_q};
    end
  end

  // read channel, one cycle from address to data
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFF_MODE: s_axi_rdata <= {27'h000_0000, mode_q};
        OFF_BW: s_axi_rdata <= {27'h000_0000, bw_q};
        OFF_HOLD: s_axi_rdata <= {25'h000_0000, hold_cfg_q};
        OFF_WORD_LO: s_axi_rdata <= hold_cfg_q[HB_RDSEL] ? hold_val_q[31:0] : word_q[31:0];
        OFF_WORD_HI: s_axi_rdata <= {24'h00_0000, hold_cfg_q[HB_RDSEL] ? hold_val_q[WORD_W-1 -: HI_W]
                                                                      : word_q[WORD_W-1 -: HI_W]};
        OFF_STATUS: s_axi_rdata <= {16'h0000, fill_q, track_ref_o, 2'h0, mode_q};
        OFF_PHASE: s_axi_rdata <= dco_phase_o[ACC_W-1 -: 32];
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // prelock2 and lost-phase are transient tracking modes, steered here like locked
  assign tracking = mode_q inside {MODE_AUTO, MODE_LOCKED, MODE_PRELOCK, MODE_PRELOCK2, MODE_LOSTPHASE};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      track_ref_o <= 1'b0;
      primary_loop_mode_o <= MODE_RESET;
      locked_loop_bw_sel_o <= BW_RESET;
    end else begin
      track_ref_o <= tracking;
      primary_loop_mode_o <= mode_q;
      locked_loop_bw_sel_o <= bw_q;
    end
  end

  // frequency steering the accumulator
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      dco_freq_o <= '0;
    end else begin
      unique case (mode_q)
        MODE_DCO: dco_freq_o <= word_q;
        MODE_HOLDOVER: dco_freq_o <= hold_val_q;
        MODE_FREERUN: dco_freq_o <= '0;
        default: dco_freq_o <= loop_freq_i;
      endcase
    end
  end

  // one word lsb adds one accumulator lsb per cycle on top of nominal, so phase drift
  // is offset times time; the nominal increment sets the lsb weight
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      dco_phase_o <= '0;
    end else begin
      dco_phase_o <= dco_phase_o + NOMINAL_INC
                     + {{(ACC_W-WORD_W){dco_freq_o[WORD_W-1]}}, dco_freq_o};
    end
  end

  // averaging filter, only fed while the loop tracks a reference
  always_comb begin
    unique case (hold_cfg_q[HB_FILT +: 2])
      2'h0: filt_shift = FILT_SHIFT_0;
      2'h1: filt_shift = FILT_SHIFT_1;
      2'h2: filt_shift = FILT_SHIFT_2;
      2'h3: filt_shift = FILT_SHIFT_3;
    endcase
  end

  assign avg_tick = (avg_div_q == AVG_DIV - 1);
  assign sec_tick = (sec_cnt_q == SEC_CYCLES - 1);
  assign avg_diff = {loop_freq_i[WORD_W-1], loop_freq_i, {FRAC_W{1'b0}}} - {avg_q[AVG_W-1], avg_q};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || avg_tick) begin
      avg_div_q <= 32'h0000_0000;
    end else begin
      avg_div_q <= avg_div_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      avg_q <= '0;
    end else if (avg_tick && tracking) begin
      avg_q <= avg_q + AVG_W'(avg_diff >>> filt_shift);
    end
  end

  // one history entry per second while tracking
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || sec_tick) begin
      sec_cnt_q <= 64'h0000_0000_0000_0000;
    end else begin
      sec_cnt_q <= sec_cnt_q + 64'h0000_0000_0000_0001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wptr_q <= '0;
      fill_q <= '0;
    end else if (sec_tick && tracking) begin
      wptr_q <= wptr_q + HIST_AW'(1);
      if (fill_q != {1'b1, {HIST_AW{1'b0}}}) begin
        fill_q <= fill_q + (HIST_AW+1)'(1);
      end
    end
  end

  always_comb begin
    unique case (hold_cfg_q[HB_HIST +: 2])
      2'h1: back = HIST_BACK_1;
      2'h2: back = HIST_BACK_8;
      2'h3: back = HIST_BACK_64;
      default: back = '0;
    endcase
  end

  hold_hist_mem #(
    .W(WORD_W),
    .AW(HIST_AW)
  ) u_hist (
    .ref_clk_i(ref_clk_i),
    .we_i(sec_tick && tracking),
    .waddr_i(wptr_q),
    .wdata_i(avg_q[AVG_W-1 -: WORD_W]),
    .raddr_i(wptr_q - back),
    .rdata_o(hist_rdata)
  );

  // until enough seconds are recorded the current average stands in
  always_comb begin
    if (hold_cfg_q[HB_MAN]) begin
      acq = word_q;
    end else if (hold_cfg_q[HB_AVG] && back != '0 && fill_q > {1'b0, back}) begin
      acq = hist_rdata;
    end else begin
      acq = avg_q[AVG_W-1 -: WORD_W];
    end
  end

  // acquired value frozen outside tracking unless the manual bit is set, so holdover keeps what was learnt
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hold_val_q <= '0;
    end else if (tracking || hold_cfg_q[HB_MAN]) begin
      hold_val_q <= acq;
    end
  end

  property p_bw_legal;
    @(posedge ref_clk_i) disable iff (rst_i)
    locked_loop_bw_sel_o <= BW_MAX;
  endproperty
  a_bw_legal: assert property (p_bw_legal) else $error("bandwidth code reserved");

  property p_prelock2_tracks;
    @(posedge ref_clk_i) disable iff (rst_i)
    mode_q == MODE_PRELOCK2 |=> track_ref_o;
  endproperty
  a_prelock2_tracks: assert property (p_prelock2_tracks) else $error("prelock2 not tracking");

  property p_lostphase_tracks;
    @(posedge ref_clk_i) disable iff (rst_i)
    mode_q == MODE_LOSTPHASE |=> track_ref_o && dco_freq_o == $past(loop_freq_i);
  endproperty
  a_lostphase_tracks: assert property (p_lostphase_tracks) else $error("lost-phase not tracking");

  property p_accum;
    @(posedge ref_clk_i) disable iff (rst_i)
    !$past(rst_i) |-> dco_phase_o == ACC_W'($past(dco_phase_o) + NOMINAL_INC
                      + {{(ACC_W-WORD_W){$past(dco_freq_o[WORD_W-1])}}, $past(dco_freq_o)});
  endproperty
  a_accum: assert property (p_accum) else $error("accumulator step wrong");

  sequence s_dco_mode;
    mode_q == MODE_DCO ##1 mode_q == MODE_DCO;
  endsequence
  property p_dco_word;
    @(posedge ref_clk_i) disable iff (rst_i)
    s_dco_mode |-> dco_freq_o == $past(word_q);
  endproperty
  a_dco_word: assert property (p_dco_word) else $error("oscillator not on written word");

  property p_partial_hold;
    @(posedge ref_clk_i) disable iff (rst_i)
    do_write && awaddr_q != OFF_WORD_HI |=> $stable(word_q);
  endproperty
  a_partial_hold: assert property (p_partial_hold) else $error("word changed before high byte");

  property p_holdover;
    @(posedge ref_clk_i) disable iff (rst_i)
    mode_q == MODE_HOLDOVER ##1 mode_q == MODE_HOLDOVER |-> !track_ref_o && dco_freq_o == $past(hold_val_q);
  endproperty
  a_holdover: assert property (p_holdover) else $error("holdover not on stored value");

  property p_manual;
    @(posedge ref_clk_i) disable iff (rst_i)
    hold_cfg_q[HB_MAN] && $past(hold_cfg_q[HB_MAN]) |-> hold_val_q == $past(word_q);
  endproperty
  a_manual: assert property (p_manual) else $error("manual holdover not on word");

  property p_readback;
    @(posedge ref_clk_i) disable iff (rst_i)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_WORD_LO |=>
      s_axi_rvalid && s_axi_rdata == ($past(hold_cfg_q[HB_RDSEL]) ? $past(hold_val_q[31:0]) : $past(word_q[31:0]));
  endproperty
  a_readback: assert property (p_readback) else $error("readback select wrong");
endmodule

// [tb/loop_src.sv]
// Purpose: stand-in for the loop integral frequency path feeding the control block
// Assumes: same clock as the control block, synchronous active-high reset
// Notes: STEP 0 follows the target at once; otherwise slews, like a settling loop
`timescale 1ns/1ps
module loop_src #(
  parameter int unsigned STEP = 0
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic signed [39:0] target_i,
  output logic signed [39:0] loop_freq_o
);
  logic signed [39:0] gap;

  assign gap = target_i - loop_freq_o;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      loop_freq_o <= '0;
    end else if (STEP == 0 || (gap < $signed(40'(STEP)) && gap > -$signed(40'(STEP)))) begin
      loop_freq_o <= target_i;
    end else if (gap > 0) begin
      loop_freq_o <= loop_freq_o + $signed(40'(STEP));
    end else begin
      loop_freq_o <= loop_freq_o - $signed(40'(STEP));
    end
  end
endmodule

// [tb/test_dpll_holdover_dco_control.sv]
// Purpose: register-level bench for the loop mode, oscillator and holdover control
// Assumes: AXI4-Lite master driven at rising edges; short second and averager counts
// Notes: filter settling checked with a window since the averager truncates
`timescale 1ns/1ps
module test_dpll_holdover_dco_control;
  import dco_ctl_pkg::*;
  localparam logic [ACC_W-1:0] INC = 48'h0000_1000_0000;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, track;
  logic [1:0] bresp, rresp, rd_r;
  logic [31:0] rdata, rd_d;
  logic [4:0] mode_o, bw_o;
  logic signed [WORD_W-1:0] target = 40'sh00_0000_03e8;
  logic signed [WORD_W-1:0] loop_freq, dco_freq;
  logic [ACC_W-1:0] phase, p0;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [4:0] codes [6] = '{MODE_HOLDOVER, MODE_LOCKED, MODE_PRELOCK2, MODE_LOSTPHASE, MODE_AUTO, MODE_PRELOCK};
  logic trk [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

  always #4 ref_clk = ~ref_clk;

  dpll_holdover_dco_control #(.SEC_CYCLES(64), .AVG_DIV(4), .NOMINAL_INC(INC)) uut (
    .ref_clk_i(ref_clk), .rst_i(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .loop_freq_i(loop_freq), .primary_loop_mode_o(mode_o), .locked_loop_bw_sel_o(bw_o),
    .track_ref_o(track), .dco_freq_o(dco_freq), .dco_phase_o(phase)
  );

  // slewing source so the averager sees a settling loop, not a step
  loop_src #(.STEP(16)) src (.ref_clk_i(ref_clk), .rst_i(rst), .target_i(target), .loop_freq_o(loop_freq));

  task automatic report_and_stop;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      t++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && t < 100);
    bready <= 1'b0;
    chk("bvalid", bvalid, 1'b1);
    chk("bresp", bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      t++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && t < 100);
    chk("rvalid", rvalid, 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, rd_d, rd_r);
    chk("rdata", rd_d, e);
    chk("rresp", rd_r, RESP_OKAY);
  endtask

  function automatic logic near(input logic signed [39:0] v);
    return v > 40'sh00_0000_1342 && v < 40'sh00_0000_13ce;
  endfunction

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop;
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    chk("mode_o", mode_o, MODE_RESET);
    chk("bw_o", bw_o, BW_RESET);
    chk("dco_freq", dco_freq, 48'h0000_0000_0000);
    rchk(OFF_BW, 32'(BW_RESET));
    rchk(OFF_HOLD, 32'(HOLD_RESET));
    rd(OFF_STATUS, rd_d, rd_r);
    chk("status", rd_d[7:0], 8'h01);
    wr(OFF_BW, 32'(BW_MAX), RESP_OKAY);
    wr(OFF_BW, 32'h0000_0016, RESP_OKAY);
    cyc(2);
    chk("bw_o", bw_o, BW_MAX);
    wr(OFF_BW, 32'h0000_0000, RESP_OKAY);
    cyc(2);
    chk("bw_o", bw_o, 5'h00);
    cyc(100);
    for (int i = 0; i < 6; i++) begin
      wr(OFF_MODE, 32'(codes[i]), RESP_OKAY);
      cyc(3);
      chk("mode_o", mode_o, codes[i]);
      chk("track", track, trk[i]);
      if (trk[i]) chk("dco_freq", dco_freq, loop_freq);
    end
    wr(OFF_MODE, 32'h0000_0003, RESP_OKAY);
    cyc(3);
    chk("mode_o", mode_o, MODE_PRELOCK);
    wr(OFF_MODE, 32'(MODE_DCO), RESP_OKAY);
    // offset of a few lsb: the low write alone leaves the word unchanged until the high byte
    wr(OFF_WORD_LO, 32'hffff_fff0, RESP_OKAY);
    cyc(3);
    chk("dco_freq", dco_freq, 48'h0000_0000_0000);
    wr(OFF_WORD_HI, 32'h0000_00ff, RESP_OKAY);
    cyc(3);
    chk("dco_freq", dco_freq, 48'hffff_ffff_fff0);
    p0 = phase;
    cyc(1);
    chk("phase_step", phase - p0, INC + 48'hffff_ffff_fff0);
    cyc(99);
    chk("phase_span", phase - p0, 48'h0000_0000_0064 * (INC + 48'hffff_ffff_fff0));
    rchk(OFF_WORD_LO, 32'hffff_fff0);
    rchk(OFF_WORD_HI, 32'h0000_00ff);
    wr(OFF_HOLD, 32'h0000_0041, RESP_OKAY);
    wr(OFF_MODE, 32'(MODE_HOLDOVER), RESP_OKAY);
    cyc(3);
    chk("dco_freq", dco_freq, 48'hffff_ffff_fff0);
    wr(OFF_MODE, 32'(MODE_LOCKED), RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_HOLD, 32'(i * 20 + 2), RESP_OKAY);
      rchk(OFF_HOLD, 32'(i * 20 + 2));
    end
    target <= 40'sh00_0000_1388;
    wr(OFF_HOLD, 32'h0000_0072, RESP_OKAY);
    cyc(2000);
    wr(OFF_MODE, 32'(MODE_HOLDOVER), RESP_OKAY);
    cyc(3);
    chk("avg_near", near(dco_freq), 1'b1);
    rd(OFF_WORD_LO, rd_d, rd_r);
    chk("readback", near(40'(rd_d)), 1'b1);
    target <= 40'sh00_0000_2328;
    cyc(300);
    chk("held", near(dco_freq), 1'b1);
    // relock onto the new target: 8 tracked seconds back still holds the old average,
    // while the current average has already moved far away
    wr(OFF_HOLD, 32'h0000_007a, RESP_OKAY);
    wr(OFF_MODE, 32'(MODE_LOCKED), RESP_OKAY);
    cyc(200);
    wr(OFF_MODE, 32'(MODE_HOLDOVER), RESP_OKAY);
    cyc(3);
    chk("hist_8s", near(dco_freq), 1'b1);
    rd(OFF_WORD_LO, rd_d, rd_r);
    chk("hist_readback", near(40'(rd_d)), 1'b1);
    wr(8'h1c, 32'h0000_0001, RESP_SLVERR);
    wr(OFF_STATUS, 32'h0000_0001, RESP_SLVERR);
    rd(8'h1c, rd_d, rd_r);
    chk("rdata", rd_d, 32'h0000_0000);
    chk("rresp", rd_r, RESP_SLVERR);
    rchk(OFF_MODE, 32'(MODE_HOLDOVER));
    report_and_stop;
  end
endmodule
